// ==== hdl/cbd_core.sv ====
// Bus tracking, cycle decode and clock gating front end of a coprocessor.
// Assumes host bus pins arrive from another domain and are synchronised here.
// Functional notes
// - Selected only with all three selects active.
// - Enable low: ignore cycle, float data and ready outputs.
// - IO select high or space low: no response.
// - Command read decodes control/status word read.
// - Command write steers word to instruction decoder.
// - Data read comes from data register path.
// - Data write steers word into operand FIFO.
// - Data alias address treated as primary.
// - Respond only when address bit 23 set.
// - Device never starts a bus cycle.
// - Bus tracking runs on host clock.
// - Idle stops section clocks within three clocks.
// - Bus tracking stays clocked while gated.
// - Selected cycle restores clocks without delay.
// - Control unit runs administrative ops alone.
// - Data path 84 bits wide.
// - Direction ignored unless fully selected.
// - Sample inputs in the strobe clock.
// - Ready out only for selected cycles.
// - Asynchronous strap disables clock gating.
`timescale 1ns/1ps
`default_nettype none

module cbd_core #(
   parameter int DATA_W = cbd_pkg::DATA_W
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire cbd_pkg::cbd_bus_in_t bus_in,
   input wire logic clock_mode_strap,
   input wire logic instr_executing,
   input wire logic [DATA_W-1:0] data_in,
   input wire logic [DATA_W-1:0] data_reg_word,
   input wire logic [DATA_W-1:0] status_word_reg,
   input wire logic status_select,
   input wire logic [cbd_pkg::DP_W-1:0] dp_in,
   output logic [DATA_W-1:0] data_out,
   output logic data_oe,
   output logic cycle_done_out_n,
   output logic cycle_done_oe,
   output logic [DATA_W-1:0] opcode_word,
   output logic opcode_valid,
   output logic [DATA_W-1:0] fifo_word,
   output logic fifo_push,
   output logic data_read_pop,
   output logic admin_op,
   output logic section_clk_en,
   output logic [cbd_pkg::SIG_W-1:0] dp_significand,
   output logic [cbd_pkg::EXP_W-1:0] dp_exponent,
   output logic dp_sign,
   output cbd_pkg::cbd_cycle_t cycle_type
);

   ////////////////////////////////////////////////////////////////////////

   typedef struct packed {
      cbd_pkg::cbd_bus_in_t sync1;
      cbd_pkg::cbd_bus_in_t sync2;
      logic [DATA_W-1:0] din1;
      logic [DATA_W-1:0] din2;
      logic strap1;
      logic strap2;
      logic phase;
      cbd_pkg::cbd_bus_state_t bstate;
      logic [1:0] rs_count;
      cbd_pkg::cbd_cycle_t cyc;
      logic drive_en;
      logic done_n;
      logic [DATA_W-1:0] dout;
      logic dout_oe;
      logic [DATA_W-1:0] ctrl_word;
      logic [DATA_W-1:0] op_word;
      logic op_valid;
      logic [DATA_W-1:0] ff_word;
      logic ff_push;
      logic rd_pop;
      logic admin;
      logic [1:0] idle_cnt;
      logic clk_en;
   } cbd_state_t;

   cbd_state_t s;
   cbd_state_t next_s;

   // Full selection decode, used by the decoder and by the assertions.
   function automatic logic is_selected(input cbd_pkg::cbd_bus_in_t b);
      is_selected = b.part_select_enable && !b.io_cycle_select_n &&
                    b.space_select;
   endfunction : is_selected

   // Escape opcode second byte patterns for the administrative group.
   function automatic logic is_admin(input logic [DATA_W-1:0] w);
      is_admin = (w[10:8] == 3'h3) &&
                 (w[7:0] == 8'hE3 || w[7:0] == 8'hE2 ||
                  w[7:0] == 8'hE4 || w[7:0] == 8'hE5);
   endfunction : is_admin

   logic tick;
   logic strobe;
   logic ready;
   logic sel;
   cbd_pkg::cbd_cycle_t dec;
   logic rdy_hit;

   ////////////////////////////////////////////////////////////////////////

   always_comb begin
      next_s = s;
      // Pins pass two flops; the first stage feeds only the second.
      next_s.sync1 = bus_in;
      next_s.sync2 = s.sync1;
      next_s.din1 = data_in;
      next_s.din2 = s.din1;
      next_s.strap1 = clock_mode_strap;
      next_s.strap2 = s.strap1;
      // Internal clock is the bus clock halved, as a one-cycle enable.
      next_s.phase = ~s.phase;
      next_s.op_valid = 1'b0;
      next_s.ff_push = 1'b0;
      next_s.rd_pop = 1'b0;
      tick = s.phase;
      strobe = !s.sync2.addr_strobe_n;
      ready = !s.sync2.bus_ready_n;
      sel = is_selected(s.sync2);
      // Address bits below bit 2 never reach the block, so the data alias
      // lands on the same decode as the primary data address.
      dec = cbd_pkg::CBD_NONE;
      if (sel) begin
         case ({s.sync2.command_vs_data_n, s.sync2.write_not_read})
            2'b00: dec = cbd_pkg::CBD_CS_READ;
            2'b01: dec = cbd_pkg::CBD_OP_WRITE;
            2'b10: dec = cbd_pkg::CBD_DATA_READ;
            default: dec = cbd_pkg::CBD_DATA_WRITE;
         endcase
      end
      rdy_hit = 1'b0;
      if (s.cyc == cbd_pkg::CBD_OP_WRITE || s.cyc == cbd_pkg::CBD_DATA_WRITE)
      begin
         rdy_hit = (s.rs_count == cbd_pkg::WRITE_RDY_STATE);
      end else if (s.cyc != cbd_pkg::CBD_NONE) begin
         rdy_hit = (s.rs_count == cbd_pkg::READ_RDY_STATE);
      end
      if (tick) begin
         next_s.done_n = 1'b1;
         // The tracker follows every cycle, selected or not; it only
         // answers cycles it decoded as its own.
         case (s.bstate)
            cbd_pkg::CBD_IDLE: begin
               if (strobe) begin
                  next_s.bstate = cbd_pkg::CBD_FIRST;
                  next_s.cyc = dec;
                  next_s.drive_en = s.sync2.part_select_enable;
                  next_s.rs_count = 2'h0;
                  if (dec != cbd_pkg::CBD_NONE) begin
                     next_s.clk_en = 1'b1;
                     next_s.idle_cnt = cbd_pkg::GATE_CNT_RST;
                  end
               end
            end
            cbd_pkg::CBD_FIRST: begin
               next_s.bstate = cbd_pkg::CBD_WAIT;
               next_s.rs_count = 2'h1;
               if (s.cyc == cbd_pkg::CBD_OP_WRITE ||
                   s.cyc == cbd_pkg::CBD_DATA_WRITE) begin
                  next_s.done_n = 1'b0;
               end
               if (s.cyc == cbd_pkg::CBD_CS_READ) begin
                  next_s.dout = status_select ? status_word_reg : s.ctrl_word;
                  next_s.dout_oe = 1'b1;
               end else if (s.cyc == cbd_pkg::CBD_DATA_READ) begin
                  next_s.dout = data_reg_word;
                  next_s.dout_oe = 1'b1;
               end
            end
            default: begin
               if (ready) begin
                  if (s.cyc == cbd_pkg::CBD_OP_WRITE) begin
                     next_s.op_word = s.din2;
                     next_s.op_valid = 1'b1;
                     next_s.admin = is_admin(s.din2);
                  end else if (s.cyc == cbd_pkg::CBD_DATA_WRITE) begin
                     next_s.ff_word = s.din2;
                     next_s.ff_push = 1'b1;
                  end else if (s.cyc == cbd_pkg::CBD_DATA_READ) begin
                     next_s.rd_pop = 1'b1;
                  end
                  // Pipelined next cycle already strobed: start it now.
                  next_s.bstate = strobe ? cbd_pkg::CBD_FIRST
                                         : cbd_pkg::CBD_IDLE;
                  next_s.cyc = strobe ? dec : cbd_pkg::CBD_NONE;
                  next_s.drive_en = strobe && s.sync2.part_select_enable;
                  next_s.dout_oe = 1'b0;
                  next_s.rs_count = 2'h0;
               end else begin
                  if (s.rs_count != 2'h3) begin
                     next_s.rs_count = s.rs_count + 2'h1;
                  end
                  if (rdy_hit == 1'b0 &&
                      s.rs_count + 2'h1 == cbd_pkg::READ_RDY_STATE &&
                      (s.cyc == cbd_pkg::CBD_CS_READ ||
                       s.cyc == cbd_pkg::CBD_DATA_READ)) begin
                     next_s.done_n = 1'b0;
                  end
               end
            end
         endcase
         // Gating counts idle internal clocks before stopping sections.
         if (s.strap2 == 1'b0) begin
            next_s.clk_en = 1'b1;
            next_s.idle_cnt = cbd_pkg::GATE_CNT_RST;
         end else if (instr_executing || s.cyc != cbd_pkg::CBD_NONE ||
                      (strobe && dec != cbd_pkg::CBD_NONE)) begin
            next_s.clk_en = 1'b1;
            next_s.idle_cnt = cbd_pkg::GATE_CNT_RST;
         end else if (s.idle_cnt == 2'(cbd_pkg::GATE_OFF_CLKS - 1)) begin
            next_s.clk_en = 1'b0;
         end else begin
            next_s.idle_cnt = s.idle_cnt + 2'h1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         s <= '{sync1: '{addr_strobe_n: 1'b1, bus_ready_n: 1'b1,
                         default: 1'b0},
                sync2: '{addr_strobe_n: 1'b1, bus_ready_n: 1'b1,
                         default: 1'b0},
                done_n: 1'b1,
                ctrl_word: cbd_pkg::CTRL_WORD_RST,
                bstate: cbd_pkg::CBD_IDLE,
                cyc: cbd_pkg::CBD_NONE,
                clk_en: 1'b1,
                default: '0};
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////

   // The device has no master side: it only answers host cycles.
   // Data and ready outputs float while the part enable is low.
   assign data_out = s.dout;
   assign data_oe = s.dout_oe && s.drive_en;
   assign cycle_done_out_n = s.done_n;
   assign cycle_done_oe = s.drive_en;
   assign opcode_word = s.op_word;
   assign opcode_valid = s.op_valid;
   assign fifo_word = s.ff_word;
   assign fifo_push = s.ff_push;
   assign data_read_pop = s.rd_pop;
   assign admin_op = s.admin;
   assign section_clk_en = s.clk_en;
   assign cycle_type = s.cyc;
   assign dp_significand = dp_in[cbd_pkg::SIG_LSB +: cbd_pkg::SIG_W];
   assign dp_exponent = dp_in[cbd_pkg::EXP_LSB +: cbd_pkg::EXP_W];
   assign dp_sign = dp_in[cbd_pkg::SIGN_POS];

   ////////////////////////////////////////////////////////////////////////

   sequence strobe_tick_s;
      s.phase && !s.sync2.addr_strobe_n && s.bstate == cbd_pkg::CBD_IDLE;
   endsequence

   sequence deselected_s;
      !s.sync2.part_select_enable;
   endsequence

   decode_select_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      strobe_tick_s and !is_selected(s.sync2) |=> s.cyc == cbd_pkg::CBD_NONE)
      else $error("Unselected cycle was decoded.");

   float_deselect_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      strobe_tick_s and deselected_s |=> !cycle_done_oe && !data_oe)
      else $error("Outputs driven while deselected.");

   opcode_steer_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      opcode_valid |-> $past(s.cyc) == cbd_pkg::CBD_OP_WRITE)
      else $error("Opcode strobe outside opcode write.");

   fifo_steer_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      fifo_push |-> $past(s.cyc) == cbd_pkg::CBD_DATA_WRITE)
      else $error("FIFO push outside data write.");

   read_drive_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      data_oe |-> s.cyc == cbd_pkg::CBD_CS_READ ||
                  s.cyc == cbd_pkg::CBD_DATA_READ)
      else $error("Data bus driven outside a read.");

   ready_select_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      !cycle_done_out_n |-> s.cyc != cbd_pkg::CBD_NONE)
      else $error("Ready asserted for unselected cycle.");

   gate_async_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      !s.strap2 ##2 !s.strap2 |-> section_clk_en)
      else $error("Clock gated in asynchronous mode.");

   gate_idle_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (s.strap2 && !instr_executing && s.cyc == cbd_pkg::CBD_NONE &&
       s.bstate == cbd_pkg::CBD_IDLE && s.sync2.addr_strobe_n)[*8]
      |-> !section_clk_en)
      else $error("Clock not gated after idle.");

   gate_wake_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      s.cyc != cbd_pkg::CBD_NONE && $past(s.cyc) == cbd_pkg::CBD_NONE
      |-> section_clk_en)
      else $error("Clock not restored for selected cycle.");

   hold_type_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      s.bstate == cbd_pkg::CBD_WAIT && !(s.phase && !s.sync2.bus_ready_n)
      |=> $stable(s.cyc))
      else $error("Cycle type changed before bus ready.");

endmodule : cbd_core

`default_nettype wire

// ==== include/cbd_pkg.sv ====
// Package for the coprocessor bus decode and power gating block.
// Assumes a single bus clock; the divided internal clock is an enable pulse.
package cbd_pkg;

   // Internal arithmetic data path layout.
   localparam int DP_W = 84;
   localparam int SIG_W = 68;
   localparam int EXP_W = 15;
   localparam int SIG_LSB = 0;
   localparam int EXP_LSB = 68;
   localparam int SIGN_POS = 83;

   localparam int DATA_W = 16;

   // Clock gating stops no later than this many internal clocks after idle.
   localparam int GATE_OFF_CLKS = 3;
   localparam logic [1:0] GATE_CNT_RST = 2'h0;

   // Ready output timing, in ready-sensitive states of the cycle.
   localparam logic [1:0] WRITE_RDY_STATE = 2'h1;
   localparam logic [1:0] READ_RDY_STATE = 2'h2;

   // Reserved coprocessor I/O addresses as the host issues them.
   localparam logic [23:0] OPCODE_ADDR = 24'h8000F8;
   localparam logic [23:0] DATA_ADDR = 24'h8000FC;
   localparam logic [23:0] DATA_ALIAS_ADDR = 24'h8000FE;

   localparam logic [DATA_W-1:0] CTRL_WORD_RST = 16'h037F;
   localparam logic [DATA_W-1:0] STAT_WORD_RST = 16'h0000;

   typedef enum logic [2:0] {
      CBD_NONE,
      CBD_CS_READ,
      CBD_OP_WRITE,
      CBD_DATA_READ,
      CBD_DATA_WRITE
   } cbd_cycle_t;

   typedef enum logic [1:0] {
      CBD_IDLE,
      CBD_FIRST,
      CBD_WAIT
   } cbd_bus_state_t;

   // Bus pins grouped as they arrive from the host.
   typedef struct packed {
      logic addr_strobe_n;
      logic bus_ready_n;
      logic part_select_enable;
      logic io_cycle_select_n;
      logic space_select;
      logic command_vs_data_n;
      logic write_not_read;
   } cbd_bus_in_t;

endpackage : cbd_pkg

// ==== testbench/cbd_host_model.sv ====
// Host bus model: runs coprocessor I/O cycles on the block's bus pins.
// Assumes the bench calls its tasks one at a time, just after a clock edge.
`timescale 1ns/1ps
`default_nettype none

module cbd_host_model (
   input wire logic ref_clk,
   input wire logic cycle_done_out_n,
   output cbd_pkg::cbd_bus_in_t bus_in,
   output logic [15:0] data_in
);

   // Tracks the bus clock halves so that cycles start in one fixed phase.
   // A real host shares reset with the block and so stays phase locked.
   logic hphase = 1'b0;

   always @(posedge ref_clk) hphase <= ~hphase;

   ////////////////////////////////////////////////////////////////////////
   initial begin
      // Idle bus: no strobe, no ready, enabled, not selected.
      bus_in = 7'h7A;
      data_in = 16'hA5C3;
   end

   // Starts a cycle and returns the edge count to the first ready out.
   task automatic start(input logic [23:0] addr, input logic wr,
      input logic en, input logic io_n, input logic [15:0] w,
      output int lat);
      do begin
         @(posedge ref_clk);
         #1;
      end while (hphase);
      bus_in.addr_strobe_n = 1'b0;
      bus_in.part_select_enable = en;
      bus_in.io_cycle_select_n = io_n;
      bus_in.space_select = addr[23];
      bus_in.command_vs_data_n = addr[2];
      bus_in.write_not_read = wr;
      // An undriven data bus shows a fresh pattern, never the last word.
      data_in = wr ? w : ~data_in;
      lat = -1;
      for (int n = 1; n < 24 && lat < 0; n++) begin
         @(posedge ref_clk);
         #1;
         if (n == 2) bus_in.addr_strobe_n = 1'b1;
         if (cycle_done_out_n === 1'b0) lat = n;
      end
   endtask : start

   // Ends the cycle after extra wait states; selects hold until then.
   task automatic finish(input int waits);
      for (int n = 0; n < waits; n++) begin
         @(posedge ref_clk);
         #1;
      end
      bus_in.bus_ready_n = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      bus_in.bus_ready_n = 1'b1;
      data_in = ~data_in;
      repeat (8) @(posedge ref_clk);
      #1;
   endtask : finish

endmodule : cbd_host_model
`default_nettype wire

// ==== testbench/cbd_core_tb.sv ====
// Self-checking bench for the bus decode and clock gating front end.
// Assumes the host model drives all bus pins; no pipelined cycles.
`timescale 1ns/1ps
`default_nettype none

module cbd_core_tb;

   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   cbd_pkg::cbd_bus_in_t bus_in;
   logic [15:0] data_in, data_out, opcode_word, fifo_word;
   logic [15:0] data_reg_word = 16'h0000;
   logic [15:0] status_word_reg = 16'h0000;
   logic clock_mode_strap = 1'b1;
   logic instr_executing = 1'b0;
   logic status_select = 1'b0;
   logic [83:0] dp_in = 84'h0;
   logic data_oe, cycle_done_out_n, cycle_done_oe, opcode_valid, fifo_push;
   logic data_read_pop, section_clk_en, dp_sign, admin_op;
   logic [cbd_pkg::SIG_W-1:0] dp_significand;
   logic [cbd_pkg::EXP_W-1:0] dp_exponent;
   cbd_pkg::cbd_cycle_t cycle_type;
   int error_cnt = 0;
   int comparisons = 0;
   int n_op = 0;
   int n_push = 0;
   int n_pop = 0;
   // Strobe passes two sync flops and waits for a tick, then ready follows
   // one internal clock later for writes and two for reads.
   localparam int WR_LAT = 6;
   logic seen_oe, seen_doe, seen_type;
   logic [31:0] rng = 32'hA8F3;

   ////////////////////////////////////////////////////////////////////////
   cbd_core cbd_core_i (.ref_clk(ref_clk), .rstn(rstn), .bus_in(bus_in),
      .clock_mode_strap(clock_mode_strap), .instr_executing(instr_executing),
      .data_in(data_in), .data_reg_word(data_reg_word),
      .status_word_reg(status_word_reg), .status_select(status_select),
      .dp_in(dp_in), .data_out(data_out), .data_oe(data_oe),
      .cycle_done_out_n(cycle_done_out_n), .cycle_done_oe(cycle_done_oe),
      .opcode_word(opcode_word), .opcode_valid(opcode_valid),
      .fifo_word(fifo_word), .fifo_push(fifo_push),
      .data_read_pop(data_read_pop), .admin_op(admin_op),
      .section_clk_en(section_clk_en), .dp_significand(dp_significand),
      .dp_exponent(dp_exponent), .dp_sign(dp_sign), .cycle_type(cycle_type));

   cbd_host_model cbd_host_model_i (.ref_clk(ref_clk),
      .cycle_done_out_n(cycle_done_out_n), .bus_in(bus_in),
      .data_in(data_in));

   always #10 ref_clk = ~ref_clk;

   // Pulses last one edge, so they are counted rather than polled.
   always @(posedge ref_clk) begin
      if (opcode_valid === 1'b1) n_op++;
      if (fifo_push === 1'b1) n_push++;
      if (data_read_pop === 1'b1) n_pop++;
      if (data_oe === 1'b1) seen_oe = 1'b1;
      if (cycle_done_oe === 1'b1) seen_doe = 1'b1;
      if (cycle_type !== cbd_pkg::CBD_NONE) seen_type = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs

   function automatic cbd_pkg::cbd_cycle_t exp_type(input logic sel,
      input logic cmd, input logic wr);
      if (!sel) return cbd_pkg::CBD_NONE;
      case ({cmd, wr})
         2'b00: return cbd_pkg::CBD_CS_READ;
         2'b01: return cbd_pkg::CBD_OP_WRITE;
         2'b10: return cbd_pkg::CBD_DATA_READ;
         default: return cbd_pkg::CBD_DATA_WRITE;
      endcase
   endfunction : exp_type

   function automatic logic exp_admin(input logic [15:0] w);
      return w[10:8] == 3'h3 &&
         (w[7:0] == 8'hE2 || w[7:0] == 8'hE3 ||
          w[7:0] == 8'hE4 || w[7:0] == 8'hE5);
   endfunction : exp_admin

   task automatic check_val(input string what, input logic [83:0] exp,
      input logic [83:0] got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : check_val

   task automatic check_type(input string what,
      input cbd_pkg::cbd_cycle_t exp, input cbd_pkg::cbd_cycle_t got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
      end
   endtask : check_type

   task automatic xfer(input logic [23:0] addr, input logic wr,
      input logic en, input logic io_n, input int waits);
      logic sel;
      logic [15:0] w;
      logic [15:0] rd;
      int lat;
      int op0;
      int pu0;
      int po0;
      cbd_pkg::cbd_cycle_t et;
      sel = en & ~io_n & addr[23];
      rng = xs(rng);
      w = rng[15:0];
      if (rng[20]) w[10:0] = 11'h3E3;
      data_reg_word = rng[31:16];
      status_word_reg = ~rng[31:16];
      et = exp_type(sel, addr[2], wr);
      rd = addr[2] ? data_reg_word :
         status_select ? status_word_reg : cbd_pkg::CTRL_WORD_RST;
      op0 = n_op;
      pu0 = n_push;
      po0 = n_pop;
      seen_oe = 1'b0;
      seen_doe = 1'b0;
      seen_type = 1'b0;
      cbd_host_model_i.start(addr, wr, en, io_n, w, lat);
      check_val("ready edge", 84'(sel ? (wr ? WR_LAT : WR_LAT + 2) + 1 : 0),
         84'(lat + 1));
      if (sel) begin
         check_type("cycle type", et, cycle_type);
         check_val("section clock", 84'h1, 84'(section_clk_en));
         if (!wr) check_val("read word", 84'(rd), 84'(data_out));
      end
      cbd_host_model_i.finish(waits);
      check_val("read drive", 84'(sel & ~wr), 84'(seen_oe));
      check_val("ready drive", 84'(en), 84'(seen_doe));
      check_val("decode", 84'(sel), 84'(seen_type));
      check_val("opcode count", 84'(et == cbd_pkg::CBD_OP_WRITE),
         84'(n_op - op0));
      check_val("fifo count", 84'(et == cbd_pkg::CBD_DATA_WRITE),
         84'(n_push - pu0));
      check_val("pop count", 84'(et == cbd_pkg::CBD_DATA_READ),
         84'(n_pop - po0));
      if (et == cbd_pkg::CBD_OP_WRITE)
         check_val("opcode word", 84'(w), 84'(opcode_word));
      if (et == cbd_pkg::CBD_OP_WRITE)
         check_val("admin op", 84'(exp_admin(w)), 84'(admin_op));
      if (et == cbd_pkg::CBD_DATA_WRITE)
         check_val("fifo word", 84'(w), 84'(fifo_word));
      check_type("end type", cbd_pkg::CBD_NONE, cycle_type);
   endtask : xfer

   task automatic summarize;
      if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : summarize

   ////////////////////////////////////////////////////////////////////////
   // About fifty cycles of at most fifty edges each fit well inside this.
   initial begin
      #1000000;
      error_cnt++;
      summarize();
   end

   initial begin
      repeat (4) @(posedge ref_clk);
      #1;
      check_val("reset ready", 84'h1, 84'(cycle_done_out_n));
      check_val("reset drive", 84'h0, 84'({data_oe, cycle_done_oe}));
      repeat (4) @(posedge ref_clk);
      #1;
      rstn = 1'b1;
      xfer(cbd_pkg::OPCODE_ADDR, 1'b0, 1'b1, 1'b0, 0);
      status_select = 1'b1;
      for (int i = 0; i < 6; i++)
         xfer(i < 2 ? cbd_pkg::OPCODE_ADDR : i < 4 ? cbd_pkg::DATA_ADDR :
            cbd_pkg::DATA_ALIAS_ADDR, 1'(i % 2), 1'b1, 1'b0, i % 3);
      xfer(cbd_pkg::DATA_ADDR, 1'b0, 1'b0, 1'b0, 0);
      xfer(cbd_pkg::DATA_ADDR, 1'b1, 1'b1, 1'b1, 0);
      xfer(24'h0000FC, 1'b0, 1'b1, 1'b0, 0);
      for (int i = 0; i < 40; i++) begin
         rng = xs(rng);
         status_select = rng[8];
         xfer(rng[3:0] == 4'h0 ? 24'h7FFFFC : rng[4] ? cbd_pkg::DATA_ALIAS_ADDR :
            rng[5] ? cbd_pkg::DATA_ADDR : cbd_pkg::OPCODE_ADDR, rng[6],
            |rng[11:9], &rng[14:12], int'(rng[17:16]));
      end
      repeat (12) @(posedge ref_clk);
      #1;
      check_val("gated clock", 84'h0, 84'(section_clk_en));
      xfer(cbd_pkg::DATA_ADDR, 1'b1, 1'b1, 1'b0, 1);
      instr_executing = 1'b1;
      repeat (20) @(posedge ref_clk);
      #1;
      check_val("busy clock", 84'h1, 84'(section_clk_en));
      instr_executing = 1'b0;
      clock_mode_strap = 1'b0;
      repeat (20) @(posedge ref_clk);
      #1;
      check_val("async clock", 84'h1, 84'(section_clk_en));
      xfer(cbd_pkg::OPCODE_ADDR, 1'b1, 1'b1, 1'b0, 2);
      for (int i = 0; i < 8; i++) begin
         rng = xs(rng);
         dp_in = {rng[19:0], ~rng, rng};
         #1;
         check_val("data path", dp_in,
            {dp_sign, dp_exponent, dp_significand});
      end
      summarize();
   end

endmodule : cbd_core_tb
`default_nettype wire
